// ### logic/cssf_status_bank.v
// Purpose: special status bank of the controller CPU on Avalon-MM, read mostly, with writable limit, duty and clear words
// Assumes: status inputs come from CPU logic on clk; slot and option pins are async
// Notes:   one wait state on every access, writes to status words are ignored except slot clears and the watchdog clear
//
// How it works
// - one bit per operating state
// - memory fitted bit follows memory presence
// - clock option bit follows clock module presence
// - halt bit high while halt executes
// - step, breakpoint, scan run bits in debug
// - bit match and word match run bits
// - fatal error bit
// - ordinary error bit
// - watchdog error bit on expiry
// - combination bit is OR of slots
// - slot bit on mismatch, insert or remove
// - system error code stored in word
// - backup good bit while backup valid
// - clock data error bit on bad setting
// - online edit bit during run edit
// - online edit failure bit
// - eight fixed square waves, 20ms to 60s
// - eight user clocks, on/off scan counts
// - watchdog limit 10 to 6000 ms
//
// The Avalon-MM slave port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "cssf_regs.vh"
module cssf_status_bank #(
	parameter integer CYC_PER_MS = `CSSF_CYC_PER_MS // shorten in simulation
) (
	input  wire        clk,
	input  wire        rst,
	// avalon-mm slave
	input  wire [7:0]  address,
	input  wire        read,
	input  wire        write,
	input  wire [31:0] writedata,
	input  wire [3:0]  byteenable,
	output wire [31:0] readdata,
	output wire        waitrequest,
	// cpu state, same clock
	input  wire [1:0]  cpu_state,
	input  wire        remote_en,
	input  wire        halt_exec,
	input  wire [2:0]  dbg_run,
	input  wire        fatal_err,
	input  wire        ordinary_err,
	input  wire        backup_ok,
	input  wire        rtc_set_bad,
	input  wire        online_edit,
	input  wire        online_edit_fail,
	input  wire [15:0] sys_err_code,
	input  wire        sys_err_we,
	input  wire        scan_start,
	input  wire        scan_end,
	// pins, asynchronous
	input  wire        mem_fitted_pin,
	input  wire        rtc_fitted_pin,
	input  wire [31:0] slot_present_pin,
	input  wire [31:0] slot_match_pin,
	// watchdog trip to the cpu
	output wire        scan_watchdog_trip
);
	// ----------------------------------------
	// encodings
	// ----------------------------------------
	localparam [1:0] ST_RUN   = 2'd0; // cpu states
	localparam [1:0] ST_PROG  = 2'd1;
	localparam [1:0] ST_PAUSE = 2'd2;
	localparam [1:0] ST_DEBUG = 2'd3;
	localparam [2:0] DR_STEP  = 3'd1; // debug run kinds
	localparam [2:0] DR_BREAK = 3'd2;
	localparam [2:0] DR_SCAN  = 3'd3;
	localparam [2:0] DR_BIT   = 3'd4;
	localparam [2:0] DR_WORD  = 3'd5;

	// one-hot decode, used for state and debug run kind
	function [7:0] cssf_dec;
		input [2:0] v;
		begin
			cssf_dec = 8'h01 << v;
		end
	endfunction

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	reg  [65:0] meta_r; // first stage, read only by sync_r
	reg  [65:0] sync_r; // second stage
	always @(posedge clk) begin
		if (rst) begin
			meta_r <= 66'h0;
			sync_r <= 66'h0;
		end else begin
			meta_r <= {mem_fitted_pin, rtc_fitted_pin, slot_present_pin, slot_match_pin};
			sync_r <= meta_r;
		end
	end
	wire        mem_fit_s  = sync_r[65];    // memory fitted
	wire        rtc_fit_s  = sync_r[64];    // clock module fitted
	wire [31:0] present_s  = sync_r[63:32]; // slot occupied
	wire [31:0] match_s    = sync_r[31:0];  // slot type matches setting

	// ----------------------------------------
	// bus handshake
	// ----------------------------------------
	reg         wait_r;    // waitrequest, idles high
	reg  [31:0] rdata_r;   // read data
	wire        req       = read | write;
	wire        take      = req & ~wait_r;           // edge where master sees answer
	wire        wr_take   = write & ~wait_r;
	wire [5:0]  widx      = address[7:2];            // word index
	wire        be_all    = byteenable[0];           // low lane carries control fields

	// one wait state, then one cycle low
	always @(posedge clk) begin
		if (rst) begin
			wait_r <= 1'b1;
		end else if (req && wait_r) begin
			wait_r <= 1'b0;
		end else begin
			wait_r <= 1'b1;
		end
	end

	// ----------------------------------------
	// mode, option and debug words
	// ----------------------------------------
	reg [15:0] mode_r;  // mode_and_option_status
	reg [15:0] dbg_r;   // debug_run_status
	reg [7:0]  st_oh;   // decoded state
	reg [7:0]  dr_oh;   // decoded debug kind
	always @* begin
		st_oh = cssf_dec({1'b0, cpu_state});
		dr_oh = cssf_dec(dbg_run);
	end

	// refreshed every cycle from cpu and pins
	always @(posedge clk) begin
		if (rst) begin
			mode_r <= 16'h0000;
			dbg_r  <= 16'h0000;
		end else begin
			mode_r                <= 16'h0000;
			mode_r[`CSSF_B_RUN]   <= st_oh[ST_RUN];
			mode_r[`CSSF_B_PROG]  <= st_oh[ST_PROG];
			mode_r[`CSSF_B_PAUSE] <= st_oh[ST_PAUSE];
			mode_r[`CSSF_B_DEBUG] <= st_oh[ST_DEBUG];
			mode_r[`CSSF_B_REMOTE] <= remote_en;
			mode_r[`CSSF_B_MEMFIT] <= mem_fit_s;
			mode_r[`CSSF_B_RTCFIT] <= rtc_fit_s;
			mode_r[`CSSF_B_HALT]   <= halt_exec;
			dbg_r <= 16'h0000;
			// run kinds only count while in debug
			if (cpu_state == ST_DEBUG) begin
				dbg_r[0] <= dr_oh[DR_STEP];
				dbg_r[1] <= dr_oh[DR_BREAK];
				dbg_r[2] <= dr_oh[DR_SCAN];
				dbg_r[3] <= dr_oh[DR_BIT];
				dbg_r[4] <= dr_oh[DR_WORD];
			end
		end
	end

	// ----------------------------------------
	// scan bits
	// ----------------------------------------
	reg first_r;  // high until first scan ends
	reg toggle_r; // flips every scan
	always @(posedge clk) begin
		if (rst) begin
			first_r  <= 1'b1;
			toggle_r <= 1'b0;
		end else if (scan_end) begin
			first_r  <= 1'b0;
			toggle_r <= ~toggle_r;
		end
	end
	wire [15:0] const_w = {11'h000, toggle_r, ~first_r, first_r, 1'b0, 1'b1};

	// ----------------------------------------
	// millisecond enable
	// ----------------------------------------
	reg [31:0] div_r;   // cycle counter
	reg        ms_tick; // one-cycle pulse per ms
	always @(posedge clk) begin
		if (rst) begin
			div_r   <= 32'h0000_0000;
			ms_tick <= 1'b0;
		end else if (div_r == CYC_PER_MS[31:0] - 32'd1) begin
			div_r   <= 32'h0000_0000;
			ms_tick <= 1'b1;
		end else begin
			div_r   <= div_r + 32'd1;
			ms_tick <= 1'b0;
		end
	end

	// ----------------------------------------
	// scan watchdog
	// ----------------------------------------
	reg [15:0] wdlim_r; // limit in ms, software written
	reg [15:0] wdcnt_r; // ms into present scan
	reg        trip_r;  // watchdog expired, sticky
	wire [15:0] wd_new = writedata[15:0];
	wire        wd_wr  = wr_take && (widx == `CSSF_OFS_WDLIM >> 2) && be_all;
	wire        over   = ms_tick && (wdcnt_r >= wdlim_r) && !scan_start;
	wire        wd_clr = wr_take && (widx == `CSSF_OFS_ERROR >> 2) && be_all
	                     && writedata[`CSSF_B_WDOG];
	// limit clamped to its legal range
	always @(posedge clk) begin
		if (rst) begin
			wdlim_r <= `CSSF_WDLIM_RST;
		end else if (wd_wr) begin
			if (wd_new < `CSSF_WDLIM_MIN) begin
				wdlim_r <= `CSSF_WDLIM_MIN;
			end else if (wd_new > `CSSF_WDLIM_MAX) begin
				wdlim_r <= `CSSF_WDLIM_MAX;
			end else begin
				wdlim_r <= wd_new;
			end
		end
	end

	// count ms per scan, restart at every scan start
	always @(posedge clk) begin
		if (rst) begin
			wdcnt_r <= 16'h0000;
			trip_r  <= 1'b0;
		end else begin
			if (scan_start) begin
				wdcnt_r <= 16'h0000;
			end else if (ms_tick && wdcnt_r != 16'hffff) begin
				wdcnt_r <= wdcnt_r + 16'd1;
			end
			// set wins over a clear in the same cycle
			if (over) begin
				trip_r <= 1'b1;
			end else if (wd_clr) begin
				trip_r <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// slot mismatch bits
	// ----------------------------------------
	reg  [31:0] slot_r;  // sticky per-slot errors
	reg  [31:0] pres_d;  // last presence, for insert/remove
	reg         pres_ok; // pres_d holds a real sample
	reg  [1:0]  fill_r;  // synchroniser fill after reset
	wire        sl_clr  = wr_take && (widx == `CSSF_OFS_SLOT >> 2);
	wire [31:0] sl_set  = (present_s & ~match_s)
	                      | ({32{pres_ok}} & (present_s ^ pres_d));
	// software clears by writing ones, hardware set wins
	always @(posedge clk) begin
		if (rst) begin
			slot_r  <= 32'h0000_0000;
			pres_d  <= 32'h0000_0000;
			pres_ok <= 1'b0;
			fill_r  <= 2'b00;
		end else begin
			pres_d  <= present_s;
			// the synchroniser resets to zero, so wait until it holds real pins
			// or every fitted slot would look freshly inserted after reset
			fill_r  <= {fill_r[0], 1'b1};
			pres_ok <= fill_r[1];
			slot_r  <= (slot_r & ~(sl_clr ? writedata : 32'h0000_0000)) | sl_set;
		end
	end

	// ----------------------------------------
	// error summary and error code
	// ----------------------------------------
	reg [15:0] err_r;  // error_summary_status
	reg [15:0] code_r; // system_error_code
	always @(posedge clk) begin
		if (rst) begin
			err_r  <= 16'h0000;
			code_r <= 16'h0000;
		end else begin
			err_r                 <= 16'h0000;
			err_r[`CSSF_B_FATAL]  <= fatal_err;
			err_r[`CSSF_B_ORD]    <= ordinary_err;
			err_r[`CSSF_B_WDOG]   <= trip_r;
			err_r[`CSSF_B_IOERR]  <= |slot_r;
			err_r[`CSSF_B_BACKUP] <= backup_ok;
			err_r[`CSSF_B_RTCERR] <= rtc_set_bad;
			err_r[`CSSF_B_EDIT]   <= online_edit;
			err_r[`CSSF_B_EDITF]  <= online_edit_fail;
			if (sys_err_we) begin
				code_r <= sys_err_code;
			end
		end
	end

	// ----------------------------------------
	// square waves and user clocks
	// ----------------------------------------
	wire [7:0] sq_w;   // fixed-period waves
	wire [7:0] uclk_w; // scan-counted clocks
	cssf_square_clocks u_sq (
		.clk     (clk),
		.rst     (rst),
		.ms_tick (ms_tick),
		.sq      (sq_w)
	);

	// duty write loads one user clock
	wire       duty_wr = wr_take && (widx == `CSSF_OFS_DUTY >> 2);
	wire [2:0] duty_sel = writedata[`CSSF_DUTY_SEL];
	wire [7:0] load_w   = duty_wr ? cssf_dec(duty_sel) : 8'h00;
	genvar g;
	generate
		for (g = 0; g < 8; g = g + 1) begin : g_uc
			cssf_user_clock u_uc (
				.clk            (clk),
				.rst            (rst),
				.scan_end       (scan_end),
				.load           (load_w[g]),
				.on_scan_count  (writedata[`CSSF_DUTY_ON]),
				.off_scan_count (writedata[`CSSF_DUTY_OFF]),
				.uclk           (uclk_w[g])
			);
		end
	endgenerate

	// ----------------------------------------
	// read mux
	// ----------------------------------------
	reg [31:0] rmux; // selected word
	always @* begin
		case (widx)
			`CSSF_OFS_MODE  >> 2: rmux = {16'h0000, mode_r};
			`CSSF_OFS_CONST >> 2: rmux = {16'h0000, const_w};
			`CSSF_OFS_DEBUG >> 2: rmux = {16'h0000, dbg_r};
			`CSSF_OFS_ERROR >> 2: rmux = {16'h0000, err_r};
			`CSSF_OFS_SLOT  >> 2: rmux = slot_r;
			`CSSF_OFS_CODE  >> 2: rmux = {16'h0000, code_r};
			`CSSF_OFS_FIXED >> 2: rmux = {24'h00_0000, sq_w};
			`CSSF_OFS_USER  >> 2: rmux = {24'h00_0000, uclk_w};
			`CSSF_OFS_WDLIM >> 2: rmux = {16'h0000, wdlim_r};
			default:              rmux = 32'h0000_0000; // unmapped reads zero
		endcase
	end

	// data latched in the wait cycle, stands through the answer
	always @(posedge clk) begin
		if (rst) begin
			rdata_r <= 32'h0000_0000;
		end else if (read && wait_r) begin
			rdata_r <= rmux;
		end
	end

	assign readdata           = rdata_r;
	assign waitrequest        = wait_r;
	assign scan_watchdog_trip = trip_r;
endmodule
`default_nettype wire

// ### logic/cssf_regs.vh
// Purpose: offsets, bit positions, reset values and timing counts of the status bank
// Assumes: 20 MHz clock, byte addresses on the register bus
// Notes:   definitions only
`ifndef CSSF_REGS_VH
`define CSSF_REGS_VH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define CSSF_OFS_MODE   8'h00
`define CSSF_OFS_CONST  8'h04
`define CSSF_OFS_DEBUG  8'h08
`define CSSF_OFS_ERROR  8'h0c
`define CSSF_OFS_SLOT   8'h10
`define CSSF_OFS_CODE   8'h14
`define CSSF_OFS_FIXED  8'h18
`define CSSF_OFS_USER   8'h1c
`define CSSF_OFS_WDLIM  8'h20
`define CSSF_OFS_DUTY   8'h24
// ----------------------------------------
// bit positions
// ----------------------------------------
`define CSSF_B_RUN      0
`define CSSF_B_PROG     1
`define CSSF_B_PAUSE    2
`define CSSF_B_DEBUG    3
`define CSSF_B_REMOTE   6
`define CSSF_B_MEMFIT   12
`define CSSF_B_RTCFIT   13
`define CSSF_B_HALT     15
`define CSSF_B_FATAL    0
`define CSSF_B_ORD      1
`define CSSF_B_WDOG     2
`define CSSF_B_IOERR    3
`define CSSF_B_BACKUP   9
`define CSSF_B_RTCERR   10
`define CSSF_B_EDIT     11
`define CSSF_B_EDITF    12
// duty register fields
`define CSSF_DUTY_SEL   26:24
`define CSSF_DUTY_ON    23:12
`define CSSF_DUTY_OFF   11:0
// ----------------------------------------
// reset values and timing
// ----------------------------------------
`define CSSF_WDLIM_RST  16'h00c8
`define CSSF_WDLIM_MIN  16'h000a
`define CSSF_WDLIM_MAX  16'h1770
`define CSSF_CLK_NS     50
`define CSSF_MS_NS      1000000
`define CSSF_CYC_PER_MS (`CSSF_MS_NS / `CSSF_CLK_NS)
// half periods of the square waves in ms, for periods of 20ms,100ms,200ms,1s,2s,10s,20s,60s
`define CSSF_HALF_MS {15'd30000, 15'd10000, 15'd5000, 15'd1000, 15'd500, 15'd100, 15'd50, 15'd10}
`endif

// ### logic/cssf_square_clocks.v
// Purpose: eight free running square waves from a shared 1 ms enable
// Assumes: ms_tick is a one-cycle pulse every millisecond
// Notes:   all bits start low after reset
`timescale 1ns/10ps
`default_nettype none
`include "cssf_regs.vh"
module cssf_square_clocks (
	input  wire        clk,
	input  wire        rst,
	input  wire        ms_tick,
	output wire [7:0]  sq
);
	// ----------------------------------------
	// one half-period counter per bit
	// ----------------------------------------
	localparam [119:0] HALF = `CSSF_HALF_MS; // packed half periods
	genvar g;
	generate
		for (g = 0; g < 8; g = g + 1) begin : g_sq
			reg [14:0] cnt_r; // ms elapsed in this half
			reg        bit_r; // wave level
			// toggle on each completed half period
			always @(posedge clk) begin
				if (rst) begin
					cnt_r <= 15'h0000;
					bit_r <= 1'b0;
				end else if (ms_tick) begin
					if (cnt_r == HALF[g*15 +: 15] - 15'd1) begin
						cnt_r <= 15'h0000;
						bit_r <= ~bit_r;
					end else begin
						cnt_r <= cnt_r + 15'd1;
					end
				end
			end
			assign sq[g] = bit_r;
		end
	endgenerate
endmodule
`default_nettype wire

// ### logic/cssf_user_clock.v
// Purpose: one scan-counted user clock
// Assumes: scan_end pulses once per scan
// Notes:   a zero off count is treated as one scan, a zero on count holds the clock low
`timescale 1ns/10ps
`default_nettype none
module cssf_user_clock (
	input  wire        clk,
	input  wire        rst,
	input  wire        scan_end,
	input  wire        load,
	input  wire [11:0] on_scan_count,
	input  wire [11:0] off_scan_count,
	output wire        uclk
);
	reg [11:0] on_r;  // programmed on scans
	reg [11:0] off_r; // programmed off scans
	reg [11:0] cnt_r; // scans spent in the present phase
	reg        lvl_r; // output level
	// ----------------------------------------
	// phase counting
	// ----------------------------------------
	// a load restarts the on phase so the new duty shows at once
	always @(posedge clk) begin
		if (rst) begin
			on_r  <= 12'h000;
			off_r <= 12'h000;
			cnt_r <= 12'h000;
			lvl_r <= 1'b0;
		end else if (load) begin
			on_r  <= on_scan_count;
			off_r <= off_scan_count;
			cnt_r <= 12'h000;
			lvl_r <= (on_scan_count != 12'h000);
		end else if (scan_end && (on_r != 12'h000)) begin
			// idle until loaded with a nonzero on count
			if (cnt_r + 12'd1 >= (lvl_r ? on_r : off_r)) begin
				cnt_r <= 12'h000;
				lvl_r <= ~lvl_r;
			end else begin
				cnt_r <= cnt_r + 12'd1;
			end
		end
	end
	assign uclk = lvl_r;
endmodule
`default_nettype wire

// ### bench/cssf_sb_checker.sv
// Purpose: bus timing and status bit checks on the bank ports
// Assumes: one clock domain, synchronous reset
// Notes:   reads are judged at the edge that sees waitrequest low
`timescale 1ns/10ps
`default_nettype none
`include "cssf_regs.vh"
module cssf_sb_checker #(
	parameter integer CYC_PER_MS = 20000 // same ms count as the bank
) (
	input wire logic        clk,
	input wire logic        rst,
	input wire logic [7:0]  address,
	input wire logic        read,
	input wire logic        write,
	input wire logic [31:0] writedata,
	input wire logic [31:0] readdata,
	input wire logic        waitrequest,
	input wire logic [1:0]  cpu_state,
	input wire logic        remote_en,
	input wire logic        halt_exec,
	input wire logic [2:0]  dbg_run,
	input wire logic        fatal_err,
	input wire logic        ordinary_err,
	input wire logic        backup_ok,
	input wire logic        rtc_set_bad,
	input wire logic        online_edit,
	input wire logic        online_edit_fail,
	input wire logic [15:0] sys_err_code,
	input wire logic        sys_err_we,
	input wire logic        scan_watchdog_trip
);
	// ------------------------------
	// helpers
	// ------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	wire         ans = read && !waitrequest; // read answered here
	logic [15:0] code_r;                     // last loaded error code
	// inputs are read two edges before the answer
	always @(posedge clk) begin
		if (rst)
			code_r <= 16'h0000;
		else if (sys_err_we)
			code_r <= sys_err_code;
	end
	// debug run bit expected in debug state only
	function automatic logic [4:0] dbg_exp(input logic [1:0] st, input logic [2:0] dr);
		dbg_exp = (st == 2'h3 && dr != 3'h0 && dr < 3'h6) ? 5'h01 << (dr - 3'h1) : 5'h00;
	endfunction
	// ------------------------------
	// assertions
	// ------------------------------
	AST_WAIT_ONE: assert property ((read || write) && waitrequest |=> !waitrequest)
		else $error("request not answered after one wait state");
	AST_WAIT_ONCE: assert property (!waitrequest |=> waitrequest)
		else $error("waitrequest low for more than one cycle");
	AST_MODE: assert property (ans && address == `CSSF_OFS_MODE |->
		readdata[3:0] == (4'h1 << $past(cpu_state, 2)) && readdata[6] == $past(remote_en, 2))
		else $error("mode bits wrong");
	AST_HALT: assert property (ans && address == `CSSF_OFS_MODE |->
		readdata[15] == $past(halt_exec, 2)) else $error("halt bit wrong");
	AST_DEBUG: assert property (ans && address == `CSSF_OFS_DEBUG |->
		readdata[4:0] == dbg_exp($past(cpu_state, 2), $past(dbg_run, 2))) else $error("debug bits wrong");
	AST_ERR_LVL: assert property (ans && address == `CSSF_OFS_ERROR |->
		readdata[1:0] == {$past(ordinary_err, 2), $past(fatal_err, 2)}) else $error("error bits wrong");
	AST_ERR_AUX: assert property (ans && address == `CSSF_OFS_ERROR |-> readdata[12:9] ==
		{$past(online_edit_fail, 2), $past(online_edit, 2), $past(rtc_set_bad, 2), $past(backup_ok, 2)})
		else $error("backup, clock or edit bits wrong");
	AST_CODE: assert property (ans && address == `CSSF_OFS_CODE |->
		readdata[15:0] == $past(code_r, 1)) else $error("error code word wrong");
	AST_CONST: assert property (ans && address == `CSSF_OFS_CONST |->
		readdata[1:0] == 2'b01 && readdata[31:16] == 16'h0000) else $error("constant bits wrong");
	AST_DOG_STICKY: assert property ($fell(scan_watchdog_trip) |->
		$past(write && !waitrequest && address == `CSSF_OFS_ERROR && writedata[2]))
		else $error("watchdog flag dropped without clear");
endmodule
`default_nettype wire

// ### bench/tb_controller_special_status_flags.sv
// Purpose: self-checking bench for the status bank
// Assumes: 20 cycles per ms so square waves stay short
// Notes:   checker bound at the foot of this file
`timescale 1ns/10ps
`default_nettype none
`include "cssf_regs.vh"
module tb_controller_special_status_flags;
	// ------------------------------
	// stimulus and observed wires
	// ------------------------------
	localparam integer CPM = 20;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [7:0]  address = 8'h00;
	logic        read = 1'b0;
	logic        write = 1'b0;
	logic [31:0] writedata = 32'h0000_0000;
	logic [31:0] readdata;
	logic        waitrequest;
	logic [1:0]  cpu_state = 2'h0;
	logic        remote_en = 1'b0;
	logic        halt_exec = 1'b0;
	logic [2:0]  dbg_run = 3'h0;
	logic [5:0]  ev = 6'h00;                 // fatal, ordinary, backup, rtc, edit, edit fail
	logic [15:0] sys_err_code = 16'h0000;
	logic        sys_err_we = 1'b0;
	logic        scan_start = 1'b0;
	logic        scan_end = 1'b0;
	logic        mem_pin = 1'b0;
	logic        rtc_pin = 1'b0;
	logic [31:0] present = 32'hffff_ffff;
	logic [31:0] match = 32'hffff_ffff;
	logic        trip;
	logic        kick = 1'b1;                // feeds the watchdog while set
	logic [31:0] q;                          // last bus answer
	int          cyc = 0;
	int          num_errors = 0;
	int          checks_done = 0;
	int          t0, t1, h, n;
	int          per[4] = '{20, 100, 200, 1000}; // square wave periods in ms
	cssf_status_bank #(.CYC_PER_MS(CPM)) dut (
		.clk(clk), .rst(rst), .address(address), .read(read), .write(write),
		.writedata(writedata), .byteenable(4'hf), .readdata(readdata), .waitrequest(waitrequest),
		.cpu_state(cpu_state), .remote_en(remote_en), .halt_exec(halt_exec), .dbg_run(dbg_run),
		.fatal_err(ev[0]), .ordinary_err(ev[1]), .backup_ok(ev[2]), .rtc_set_bad(ev[3]),
		.online_edit(ev[4]), .online_edit_fail(ev[5]), .sys_err_code(sys_err_code),
		.sys_err_we(sys_err_we), .scan_start(scan_start), .scan_end(scan_end),
		.mem_fitted_pin(mem_pin), .rtc_fitted_pin(rtc_pin), .slot_present_pin(present),
		.slot_match_pin(match), .scan_watchdog_trip(trip));
	always #25 clk = ~clk;
	// cycle count, scan starts every 50 cycles, run limit
	always @(posedge clk) begin
		cyc <= cyc + 1;
		scan_start <= kick && (cyc % 50 == 0);
		if (cyc > 90000) begin
			num_errors++;
			summarize;
		end
	end
	// ------------------------------
	// tasks
	// ------------------------------
	task chk(input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e) begin
			num_errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	// one bus access, held until waitrequest is seen low
	task acc(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge clk);
		address <= a;
		writedata <= d;
		read <= !w;
		write <= w;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (waitrequest !== 1'b0 && k < 50);
		if (k == 50) begin
			num_errors++;
			summarize;
		end
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask
	task ck(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		acc(1'b0, a, 32'h0000_0000);
		chk(q & m, e);
	endtask
	task sp(input int c);
		repeat (c) begin
			@(posedge clk);
			scan_end <= 1'b1;
			@(posedge clk);
			scan_end <= 1'b0;
		end
	endtask
	// poll a fixed clock bit until it leaves level v
	task pw(input int b, input logic v, output int t);
		n = 0;
		do begin
			acc(1'b0, `CSSF_OFS_FIXED, 32'h0000_0000);
			n++;
		end while (q[b] === v && n < 4000);
		if (n == 4000) begin
			num_errors++;
			summarize;
		end
		t = cyc;
	endtask
	task summarize;
		$display("checks %0d mismatches %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// ------------------------------
	// main sequence
	// ------------------------------
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		ck(`CSSF_OFS_CONST, 32'hffff_ffff, 32'h0000_0005);
		ck(`CSSF_OFS_WDLIM, 32'hffff_ffff, 32'h0000_00c8);
		sp(1);
		ck(`CSSF_OFS_CONST, 32'hffff_ffff, 32'h0000_0019);
		sp(1);
		acc(1'b1, `CSSF_OFS_CONST, 32'h0000_0000);
		ck(`CSSF_OFS_CONST, 32'hffff_ffff, 32'h0000_0009);
		$display("constant test done");
		for (int i = 0; i < 8; i++) begin
			cpu_state <= i[1:0];
			remote_en <= i[2];
			halt_exec <= i[0];
			ck(`CSSF_OFS_MODE, 32'hffff_ffff, {16'h0000, i[0], 8'h00, i[2], 2'b00, 4'h1 << i[1:0]});
		end
		$display("mode test done");
		for (int d = 0; d < 6; d++) begin
			cpu_state <= 2'h3;
			dbg_run <= d[2:0];
			ck(`CSSF_OFS_DEBUG, 32'hffff_ffff, d == 0 ? 32'h0000_0000 : 32'h0000_0001 << (d - 1));
		end
		cpu_state <= 2'h0;
		ck(`CSSF_OFS_DEBUG, 32'hffff_ffff, 32'h0000_0000);
		$display("debug test done");
		for (int k = 0; k < 7; k++) begin
			ev <= 6'h01 << k;
			ck(`CSSF_OFS_ERROR, 32'h0000_1e03,
			   k < 2 ? 32'h0000_0001 << k : (k < 6 ? 32'h0000_0001 << (k + 7) : 32'h0000_0000));
		end
		$display("error level test done");
		sys_err_code <= 16'h0031;
		sys_err_we <= 1'b1;
		@(posedge clk);
		sys_err_we <= 1'b0;
		ck(`CSSF_OFS_CODE, 32'hffff_ffff, 32'h0000_0031);
		acc(1'b1, `CSSF_OFS_CODE, 32'h0000_1234);
		ck(`CSSF_OFS_CODE, 32'hffff_ffff, 32'h0000_0031);
		ck(8'h30, 32'hffff_ffff, 32'h0000_0000);
		$display("code test done");
		mem_pin <= 1'b1;
		rtc_pin <= 1'b1;
		acc(1'b1, `CSSF_OFS_SLOT, 32'hffff_ffff);
		ck(`CSSF_OFS_MODE, 32'h0000_3000, 32'h0000_3000);
		ck(`CSSF_OFS_SLOT, 32'hffff_ffff, 32'h0000_0000);
		match[5] <= 1'b0;
		repeat (4) @(posedge clk);
		ck(`CSSF_OFS_SLOT, 32'hffff_ffff, 32'h0000_0020);
		ck(`CSSF_OFS_ERROR, 32'h0000_0008, 32'h0000_0008);
		match[5] <= 1'b1;
		acc(1'b1, `CSSF_OFS_SLOT, 32'h0000_0020);
		ck(`CSSF_OFS_ERROR, 32'h0000_0008, 32'h0000_0000);
		present[31] <= 1'b0;
		mem_pin <= 1'b0;
		repeat (4) @(posedge clk);
		ck(`CSSF_OFS_SLOT, 32'hffff_ffff, 32'h8000_0000);
		ck(`CSSF_OFS_MODE, 32'h0000_1000, 32'h0000_0000);
		$display("slot test done");
		acc(1'b1, `CSSF_OFS_WDLIM, 32'h0000_0005);
		ck(`CSSF_OFS_WDLIM, 32'h0000_ffff, 32'h0000_000a);
		acc(1'b1, `CSSF_OFS_WDLIM, 32'h0000_1b58);
		ck(`CSSF_OFS_WDLIM, 32'h0000_ffff, 32'h0000_1770);
		acc(1'b1, `CSSF_OFS_WDLIM, 32'h0000_000a);
		kick <= 1'b0;
		repeat (100) @(posedge clk);
		chk({31'h0000_0000, trip}, 32'h0000_0000);
		n = 0;
		while (trip !== 1'b1 && n < 300) begin
			@(posedge clk);
			n++;
		end
		chk({31'h0000_0000, trip}, 32'h0000_0001);
		ck(`CSSF_OFS_ERROR, 32'h0000_0004, 32'h0000_0004);
		kick <= 1'b1;
		// let a scan start restart the count, else the next tick trips again
		repeat (60) @(posedge clk);
		acc(1'b1, `CSSF_OFS_ERROR, 32'h0000_0004);
		ck(`CSSF_OFS_ERROR, 32'h0000_0004, 32'h0000_0000);
		$display("watchdog test done");
		acc(1'b1, `CSSF_OFS_DUTY, {5'h00, 3'h2, 12'h003, 12'h002});
		ck(`CSSF_OFS_USER, 32'h0000_0004, 32'h0000_0004);
		sp(2);
		ck(`CSSF_OFS_USER, 32'h0000_0004, 32'h0000_0004);
		sp(1);
		ck(`CSSF_OFS_USER, 32'h0000_0004, 32'h0000_0000);
		sp(1);
		ck(`CSSF_OFS_USER, 32'h0000_0004, 32'h0000_0000);
		sp(1);
		ck(`CSSF_OFS_USER, 32'h0000_0004, 32'h0000_0004);
		for (int s = 0; s < 8; s++) begin
			acc(1'b1, `CSSF_OFS_DUTY, {5'h00, s[2:0], 12'h001, 12'h001});
			ck(`CSSF_OFS_USER, 32'h0000_0001 << s, 32'h0000_0001 << s);
		end
		$display("user clock test done");
		for (int b = 0; b < 4; b++) begin
			acc(1'b0, `CSSF_OFS_FIXED, 32'h0000_0000);
			pw(b, q[b], t0);
			pw(b, q[b], t1);
			h = per[b] * CPM / 2;
			chk({31'h0000_0000, (t1 - t0 >= h - 8) && (t1 - t0 <= h + 8)}, 32'h0000_0001);
		end
		$display("square wave test done");
		summarize;
	end
endmodule
bind cssf_status_bank cssf_sb_checker #(.CYC_PER_MS(CYC_PER_MS)) u_chk (
	.clk(clk), .rst(rst), .address(address), .read(read), .write(write), .writedata(writedata),
	.readdata(readdata), .waitrequest(waitrequest), .cpu_state(cpu_state), .remote_en(remote_en),
	.halt_exec(halt_exec), .dbg_run(dbg_run), .fatal_err(fatal_err), .ordinary_err(ordinary_err),
	.backup_ok(backup_ok), .rtc_set_bad(rtc_set_bad), .online_edit(online_edit),
	.online_edit_fail(online_edit_fail), .sys_err_code(sys_err_code), .sys_err_we(sys_err_we),
	.scan_watchdog_trip(scan_watchdog_trip));
`default_nettype wire
